// ---- core/psc_top.sv ----
// sideband and system-control logic of the processor, device side
// assumes all sideband pins are asynchronous and active high at this boundary;
// registers are reached over a classic wishbone slave on the same clock
// Functional notes
// - each 16-bit data group and its invert bit latch on own strobe bit
// - shared error/break output: fp error when no stop clock, break event otherwise
// - break indication on shared output holds until stop clock request drops
// - snoop stall asserts hit and hit-modified together, repeatable to extend
// - ignore-numeric-error masks fp exception unless numeric-error-enable set
// - soft init resets integer state, keeps caches, snoops, restarts at vector
// - soft init seen at hard reset release starts built-in self-test
// - with local irq controller off, pin0 is maskable irq, pin1 nonmaskable
// - bus lock held from first to last transaction of a locked sequence
// - overtemp flag drives on internal throttle only; bidirectional mode input starts throttle
// - hard reset returns known state and invalidates caches without writeback
// - outputs deasserted within two bus clocks of hard reset
// - sleep request in stop-grant enters sleep, clocks stop, snoops ignored
// - sleep responds only to reset, sleep release and deep-sleep request
// - sleep release returns to stop-grant and restarts the bus clock, core clock stays gated
// - deep-sleep request in sleep enters deep sleep
// - accepted management irq saves state, enters management mode, acks
// - management irq at hard reset release tristates outputs
// - stop clock request enters stop-grant, acks, gates core clocks
// - deep-sleep release in deep sleep returns to sleep
module psc_top
   import psc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hard_reset_i,
   input wire logic stop_clock_req_i,
   input wire logic sleep_req_i,
   input wire logic deep_sleep_req_i,
   input wire logic ignore_numeric_error_i,
   input wire logic soft_init_i,
   input wire logic sys_mgmt_irq_i,
   input wire logic [1:0] local_irq_pins_i,
   input wire logic overtemp_flag_i,
   input wire logic snoop_req_i,
   input wire logic [3:0] data_strobe_pos_i,
   input wire logic [63:0] data_i,
   input wire logic [3:0] data_invert_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic fp_error_out_o,
   output logic internal_error_out_o,
   output logic [2:0] bus_txn_o,
   output logic fp_exception_o,
   output logic maskable_irq_o,
   output logic nmi_o,
   output logic [1:0] local_irq_o,
   output logic bus_lock_o,
   output logic snoop_hit_o,
   output logic snoop_hit_modified_o,
   output logic overtemp_flag_o,
   output logic overtemp_flag_oe_o,
   output logic throttle_active_o,
   output logic core_clk_en_o,
   output logic bus_clk_en_o,
   output logic sys_mgmt_mode_o,
   output logic builtin_self_test_o,
   output logic cache_invalidate_o,
   output logic int_reg_reset_o,
   output logic outputs_tristate_o,
   output logic [3:0] pwr_state_o
);
   // synchroniser stages for every asynchronous sideband input
   logic [PSC_SYNC_W-1:0] sync1_q;
   logic [PSC_SYNC_W-1:0] sync2_q;
   logic [PSC_SYNC_W-1:0] async_in;
   logic hrst_s, stop_clock_req_s, slp_s, dslp_s, ign_s, init_s, smi_s, hot_s;
   logic [1:0] lint_s;
   logic snp_s;
   logic hrst_prev_q;
   logic [7:0] ctrl_q;
   logic fperr_q, brk_q, internal_error_out_q, therm_q, brk_latched_q;
   logic smm_pend_q;
   logic lock_hold_q;
   logic [1:0] stall_cnt_q;
   logic [63:0] data_lat_q;
   logic [3:0] inv_lat_q;
   logic wb_hit;
   logic [3:0] wb_ofs;
   logic wr_evt;
   logic hrst_fall;
   psc_pwr_t pwr_q;

   // pin levels gathered for the synchroniser, top bit is a spare
   assign async_in = {1'b0, snoop_req_i, local_irq_pins_i, overtemp_flag_i, sys_mgmt_irq_i,
      soft_init_i, ignore_numeric_error_i, deep_sleep_req_i, sleep_req_i, stop_clock_req_i,
      hard_reset_i};

   // two-flop synchroniser, second stage is the only reader of the first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end
   assign {snp_s, lint_s, hot_s, smi_s, init_s, ign_s, dslp_s, slp_s, stop_clock_req_s, hrst_s}
      = sync2_q[10:0];

   // hard reset edge tracking
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hrst_prev_q <= 1'b0;
      end else begin
         hrst_prev_q <= hrst_s;
      end
   end
   assign hrst_fall = hrst_prev_q && !hrst_s;

   // wishbone decode
   assign wb_ofs = (wb_adr_i[31:4] == 28'h0000000) ? wb_adr_i[3:0] : 4'h1; // no aliasing above map
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_evt = wb_hit && wb_we_i && wb_sel_i[0] && (wb_ofs == PSC_EVT_OFS);

   // single-wait-state slave: ack one cycle after strobe, read data registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= 32'h0000_0000;
         if (wb_hit && !wb_we_i) begin
            unique case (wb_ofs)
               PSC_CTRL_OFS: wb_dat_o <= {24'h000000, ctrl_q};
               PSC_STAT_OFS: wb_dat_o <= {16'h0000, inv_lat_q, pwr_q, sys_mgmt_mode_o,
                  throttle_active_o, brk_latched_q, internal_error_out_q, fperr_q, lock_hold_q,
                  builtin_self_test_o, outputs_tristate_o};
               PSC_EVT_OFS: wb_dat_o <= {28'h0000000, therm_q, internal_error_out_q, brk_q, fperr_q};
               PSC_DATA_LO_OFS: wb_dat_o <= data_lat_q[31:0];
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= PSC_CTRL_RST; // local irq controller enabled by default
      end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_ofs == PSC_CTRL_OFS) begin
         ctrl_q <= wb_dat_i[7:0];
      end
   end

   // internal event flags raised by core-side writes; hard reset clears them
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         fperr_q <= 1'b0;
         brk_q <= 1'b0;
         internal_error_out_q <= 1'b0;
         therm_q <= 1'b0;
      end else begin
         if (wr_evt && wb_dat_i[PSC_EVT_FPERR_BIT]) begin
            fperr_q <= 1'b1;
         end else if (wr_evt && wb_dat_i[PSC_EVT_FPCLR_BIT]) begin
            fperr_q <= 1'b0;
         end
         if (wr_evt && wb_dat_i[PSC_EVT_BREAK_BIT]) begin
            brk_q <= 1'b1;
         end else if (!stop_clock_req_s) begin
            brk_q <= 1'b0;
         end
         if (wr_evt && wb_dat_i[PSC_EVT_INTERNAL_ERROR_OUT_BIT]) begin
            internal_error_out_q <= 1'b1;
         end
         if (wr_evt) begin
            therm_q <= wb_dat_i[PSC_EVT_THERM_BIT];
         end
      end
   end

   // break indication latches while stop clock is active
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         brk_latched_q <= 1'b0;
      end else if (!stop_clock_req_s) begin
         brk_latched_q <= 1'b0;
      end else if (brk_q) begin
         brk_latched_q <= 1'b1;
      end
   end

   // shared error/break output and numeric exception
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         fp_error_out_o <= 1'b0;
         fp_exception_o <= 1'b0;
      end else begin
         fp_error_out_o <= stop_clock_req_s ? (brk_q || brk_latched_q) : fperr_q;
         fp_exception_o <= fperr_q && (ctrl_q[PSC_CTRL_NE_BIT] || !ign_s);
      end
   end

   // internal error output and bus transaction requests
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         internal_error_out_o <= 1'b0;
         bus_txn_o <= PSC_TXN_NONE;
      end else begin
         internal_error_out_o <= internal_error_out_q;
         bus_txn_o <= PSC_TXN_NONE;
         if (wr_evt && wb_dat_i[PSC_EVT_INTERNAL_ERROR_OUT_BIT]) begin
            bus_txn_o <= PSC_TXN_HALT;
         end else if (pwr_q == PSC_NORMAL && stop_clock_req_s) begin
            bus_txn_o <= PSC_TXN_STOPACK;
         end else if (smi_s && !smm_pend_q && pwr_q == PSC_NORMAL) begin
            bus_txn_o <= PSC_TXN_SMIACK;
         end
      end
   end

   // management mode entry and exit
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         smm_pend_q <= 1'b0;
         sys_mgmt_mode_o <= 1'b0;
      end else begin
         if (smi_s && !smm_pend_q && pwr_q == PSC_NORMAL && !stop_clock_req_s) begin
            smm_pend_q <= 1'b1;
            sys_mgmt_mode_o <= 1'b1;
         end else if (wr_evt && wb_dat_i[PSC_EVT_SMIDONE_BIT]) begin
            smm_pend_q <= 1'b0;
            sys_mgmt_mode_o <= 1'b0;
         end
      end
   end

   // reset sequencing: cache invalidate, self-test, tristate, soft init
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cache_invalidate_o <= 1'b0;
         builtin_self_test_o <= 1'b0;
         outputs_tristate_o <= 1'b0;
         int_reg_reset_o <= 1'b0;
      end else begin
         cache_invalidate_o <= hrst_s;
         int_reg_reset_o <= hrst_s || (init_s && pwr_q == PSC_NORMAL);
         if (hrst_fall) begin
            builtin_self_test_o <= init_s;
            outputs_tristate_o <= smi_s;
         end else if (hrst_s) begin
            builtin_self_test_o <= 1'b0;
            outputs_tristate_o <= 1'b0;
         end
      end
   end

   // local interrupt pin remapping
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         maskable_irq_o <= 1'b0;
         nmi_o <= 1'b0;
         local_irq_o <= 2'h0;
      end else if (ctrl_q[PSC_CTRL_LOCAL_IRQ_CTRL_EN_BIT]) begin
         maskable_irq_o <= 1'b0;
         nmi_o <= 1'b0;
         local_irq_o <= lint_s;
      end else begin
         maskable_irq_o <= lint_s[0];
         nmi_o <= lint_s[1];
         local_irq_o <= 2'h0;
      end
   end

   // bus lock held across the whole locked sequence set by software
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         lock_hold_q <= 1'b0;
         bus_lock_o <= 1'b0;
      end else begin
         lock_hold_q <= ctrl_q[PSC_CTRL_LOCK_BIT];
         bus_lock_o <= ctrl_q[PSC_CTRL_LOCK_BIT];
      end
   end

   // snoop stall: both lines together for two cycles per requested stall
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         stall_cnt_q <= 2'h0;
         snoop_hit_o <= 1'b0;
         snoop_hit_modified_o <= 1'b0;
      end else begin
         if (snp_s && ctrl_q[PSC_CTRL_STALL_BIT] &&
            pwr_q != PSC_SLEEP && pwr_q != PSC_DSLEEP) begin
            stall_cnt_q <= 2'h2;
         end else if (stall_cnt_q != 2'h0) begin
            stall_cnt_q <= stall_cnt_q - 2'h1;
         end
         snoop_hit_o <= (stall_cnt_q != 2'h0);
         snoop_hit_modified_o <= (stall_cnt_q != 2'h0);
      end
   end

   // thermal throttle and overtemp pin
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         throttle_active_o <= 1'b0;
         overtemp_flag_o <= 1'b0;
         overtemp_flag_oe_o <= 1'b0;
      end else begin
         throttle_active_o <= therm_q || (ctrl_q[PSC_CTRL_HOT_BIDIR_BIT] && hot_s);
         overtemp_flag_o <= therm_q;
         overtemp_flag_oe_o <= therm_q;
      end
   end

   // data strobe latching per group
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_lat_q <= 64'h0;
         inv_lat_q <= 4'h0;
      end else begin
         for (int g = 0; g < PSC_STROBE_GROUPS; g++) begin
            if (data_strobe_pos_i[g]) begin
               data_lat_q[g*PSC_GROUP_W +: PSC_GROUP_W] <=
                  data_i[g*PSC_GROUP_W +: PSC_GROUP_W];
               inv_lat_q[g] <= data_invert_i[g];
            end
         end
      end
   end

   // power state machine
   always_ff @(posedge clk_i) begin
      if (rst_i || hrst_s) begin
         pwr_q <= PSC_NORMAL;
      end else begin
         unique case (pwr_q)
            PSC_NORMAL: if (stop_clock_req_s) pwr_q <= PSC_STOPGNT;
            PSC_STOPGNT: begin
               if (slp_s) pwr_q <= PSC_SLEEP;
               else if (!stop_clock_req_s) pwr_q <= PSC_NORMAL;
            end
            PSC_SLEEP: begin
               if (!slp_s) pwr_q <= PSC_STOPGNT;
               else if (dslp_s) pwr_q <= PSC_DSLEEP;
            end
            PSC_DSLEEP: if (!dslp_s) pwr_q <= PSC_SLEEP;
            default: pwr_q <= PSC_NORMAL;
         endcase
      end
   end

   // clock gating outputs follow the power state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_clk_en_o <= 1'b1;
         bus_clk_en_o <= 1'b1;
         pwr_state_o <= PSC_NORMAL;
      end else begin
         core_clk_en_o <= (pwr_q == PSC_NORMAL);
         bus_clk_en_o <= (pwr_q == PSC_NORMAL) || (pwr_q == PSC_STOPGNT);
         pwr_state_o <= pwr_q;
      end
   end

   // checks
   shared_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!hrst_s && !$past(hrst_s) && !stop_clock_req_s && fperr_q) |=> fp_error_out_o)
      else $error("fp error not shown");
   break_hold_a: assert property (@(posedge clk_i) disable iff (rst_i || hrst_s)
      (brk_latched_q && stop_clock_req_s) |=> fp_error_out_o)
      else $error("break indication dropped");
   stall_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      snoop_hit_o == snoop_hit_modified_o) else $error("stall lines differ");
   sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i || hrst_s)
      (pwr_q == PSC_STOPGNT && slp_s) |=> pwr_q == PSC_SLEEP)
      else $error("sleep not entered");
   deep_exit_a: assert property (@(posedge clk_i) disable iff (rst_i || hrst_s)
      (pwr_q == PSC_DSLEEP && !dslp_s) |=> pwr_q == PSC_SLEEP)
      else $error("deep sleep not left");
   reset_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hrst_s |-> ##[1:2] !bus_lock_o && !snoop_hit_o) else $error("outputs not quiet");
   irq_remap_a: assert property (@(posedge clk_i) disable iff (rst_i || hrst_s)
      (!ctrl_q[PSC_CTRL_LOCAL_IRQ_CTRL_EN_BIT] && $stable(ctrl_q)) |=> maskable_irq_o == $past(lint_s[0]))
      else $error("irq pin not remapped");
   builtin_self_test_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (hrst_fall && init_s) |=> builtin_self_test_o) else $error("self test missed");
endmodule // psc_top

// ---- core/psc_pkg.sv ----
// package for the processor sideband control block
// assumes a single 10 MHz bus clock and synchronous active-high reset
package psc_pkg;
   localparam int unsigned PSC_CLK_HZ = 10000000;
   localparam int unsigned PSC_STROBE_GROUPS = 4;
   localparam int unsigned PSC_GROUP_W = 16;
   localparam int unsigned PSC_DATA_W = 64;
   localparam int unsigned PSC_SYNC_W = 12;
   // register offsets (byte addresses)
   localparam logic [3:0] PSC_CTRL_OFS = 4'h0;
   localparam logic [3:0] PSC_STAT_OFS = 4'h4;
   localparam logic [3:0] PSC_EVT_OFS = 4'h8;
   localparam logic [3:0] PSC_DATA_LO_OFS = 4'hc;
   // control fields
   localparam int unsigned PSC_CTRL_NE_BIT = 0;
   localparam int unsigned PSC_CTRL_LOCAL_IRQ_CTRL_EN_BIT = 1;
   localparam int unsigned PSC_CTRL_HOT_BIDIR_BIT = 2;
   localparam int unsigned PSC_CTRL_LOCK_BIT = 3;
   localparam int unsigned PSC_CTRL_STALL_BIT = 4;
   localparam logic [7:0] PSC_CTRL_RST = 8'h02;
   // event register fields (write one to raise; FPCLR and SMIDONE write one to clear; THERM takes the written value on every event write)
   localparam int unsigned PSC_EVT_FPERR_BIT = 0;
   localparam int unsigned PSC_EVT_BREAK_BIT = 1;
   localparam int unsigned PSC_EVT_INTERNAL_ERROR_OUT_BIT = 2;
   localparam int unsigned PSC_EVT_THERM_BIT = 3;
   localparam int unsigned PSC_EVT_FPCLR_BIT = 4;
   localparam int unsigned PSC_EVT_SMIDONE_BIT = 5;
   // bus transaction codes
   localparam logic [2:0] PSC_TXN_NONE = 3'h0;
   localparam logic [2:0] PSC_TXN_HALT = 3'h1;
   localparam logic [2:0] PSC_TXN_STOPACK = 3'h2;
   localparam logic [2:0] PSC_TXN_SMIACK = 3'h3;
   localparam int unsigned PSC_OUT_OFF_CYC = 1;
   typedef enum logic [3:0] {
      PSC_NORMAL = 4'b0001,
      PSC_STOPGNT = 4'b0010,
      PSC_SLEEP = 4'b0100,
      PSC_DSLEEP = 4'b1000
   } psc_pwr_t;
endpackage

// ---- bench/psc_chipset_model.sv ----
// chipset model: drives power, reset, init and irq levels and the strobed data groups
// assumes the device clock and the registered transaction code and bus lock of the device
module psc_chipset_model
   import psc_pkg::*;
#(
   parameter int POR_CYC = 20000
)
(
   input wire logic clk_i,
   input wire logic [2:0] bus_txn_i,
   input wire logic bus_lock_i,
   output logic hard_reset_o,
   output logic stop_clock_req_o,
   output logic sleep_req_o,
   output logic deep_sleep_req_o,
   output logic soft_init_o,
   output logic sys_mgmt_irq_o,
   output logic [3:0] data_strobe_pos_o,
   output logic [63:0] data_o,
   output logic [3:0] data_invert_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int halt_seen = 0;
   int stopack_seen = 0;
   int smiack_seen = 0;
   logic target_ready = 1'b0;
   logic prio_req = 1'b0;
   // power-on levels: reset held, every request idle
   initial begin
      hard_reset_o = 1'b1;
      {stop_clock_req_o, sleep_req_o, deep_sleep_req_o} = 3'h0;
      {soft_init_o, sys_mgmt_irq_o} = 2'h0;
      data_strobe_pos_o = 4'h0;
      data_o = 64'h0;
      data_invert_o = 4'h0;
   end
   // tally the transactions the device issues
   always @(posedge clk_i) begin
      if (bus_txn_i == PSC_TXN_HALT) halt_seen <= halt_seen + 1;
      if (bus_txn_i == PSC_TXN_STOPACK) stopack_seen <= stopack_seen + 1;
      if (bus_txn_i == PSC_TXN_SMIACK) smiack_seen <= smiack_seen + 1;
   end
   // hard reset of cyc plus 4 cycles, released with init and irq levels already present
   task automatic hard_reset(input int cyc, input logic init, input logic smi);
      @(posedge clk_i);
      hard_reset_o <= 1'b1;
      {stop_clock_req_o, sleep_req_o, deep_sleep_req_o} <= 3'h0;
      repeat (cyc) @(posedge clk_i);
      soft_init_o <= init;
      sys_mgmt_irq_o <= smi;
      repeat (4) @(posedge clk_i);
      hard_reset_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      {soft_init_o, sys_mgmt_irq_o} <= 2'h0;
   endtask
   // power requests change together after an edge
   task automatic power(input logic stop, input logic slp, input logic deep);
      @(posedge clk_i);
      stop_clock_req_o <= stop;
      sleep_req_o <= slp;
      deep_sleep_req_o <= deep;
   endtask
   // soft init presented along with target ready of an io write
   task automatic soft_init(input logic v);
      @(posedge clk_i);
      soft_init_o <= v;
      target_ready <= v;
   endtask
   task automatic smi(input logic v);
      @(posedge clk_i);
      sys_mgmt_irq_o <= v;
   endtask
   // one strobe burst; afterwards the released bus shows the inverse, not stale data
   task automatic strobe(input logic [3:0] g, input logic [63:0] d, input logic [3:0] inv);
      @(posedge clk_i);
      data_strobe_pos_o <= g;
      data_o <= d;
      data_invert_o <= inv;
      @(posedge clk_i);
      data_strobe_pos_o <= 4'h0;
      data_o <= ~d;
      data_invert_o <= ~inv;
   endtask
   // priority agent takes the bus once the lock line is seen low, or after 100 cycles of waiting
   task automatic prio_grab(output int waited);
      waited = 0;
      while (bus_lock_i === 1'b1 && waited < 100) begin
         @(posedge clk_i);
         waited++;
      end
      prio_req <= 1'b1;
      @(posedge clk_i);
      prio_req <= 1'b0;
   endtask
endmodule // psc_chipset_model

// ---- bench/psc_top_tb.sv ----
// self-checking bench of the sideband control block: wishbone tasks and sideband levels
// assumes the chipset model for power, reset, init and strobes; sync lag is 3 cycles
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
`define WAITHI(s) begin n = 0; while ((s) !== 1'b1 && n < 20) begin @(negedge clk_i); \
   n++; end end
module psc_top_tb
   import psc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ignore_numeric_error_i = 1'b0, overtemp_flag_i = 1'b0, snoop_req_i = 1'b0;
   logic [1:0] local_irq_pins_i = 2'h0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, rdat;
   logic [3:0] wb_sel_i = 4'hf;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   wire logic hard_reset_i, stop_clock_req_i, sleep_req_i, deep_sleep_req_i;
   wire logic soft_init_i, sys_mgmt_irq_i;
   wire logic [3:0] data_strobe_pos_i, data_invert_i;
   wire logic [63:0] data_i;
   logic [31:0] wb_dat_o;
   logic [3:0] pwr_state_o;
   logic [2:0] bus_txn_o;
   logic [1:0] local_irq_o;
   logic wb_ack_o, fp_error_out_o, internal_error_out_o, fp_exception_o, maskable_irq_o;
   logic nmi_o, bus_lock_o, snoop_hit_o, snoop_hit_modified_o, overtemp_flag_o;
   logic overtemp_flag_oe_o, throttle_active_o, core_clk_en_o, bus_clk_en_o;
   logic sys_mgmt_mode_o, builtin_self_test_o, cache_invalidate_o, int_reg_reset_o;
   logic outputs_tristate_o;
   int checked = 0, miscompares = 0, n, waited;
   psc_top i_dut (.clk_i, .rst_i, .hard_reset_i, .stop_clock_req_i, .sleep_req_i,
      .deep_sleep_req_i, .ignore_numeric_error_i, .soft_init_i, .sys_mgmt_irq_i,
      .local_irq_pins_i, .overtemp_flag_i, .snoop_req_i, .data_strobe_pos_i, .data_i,
      .data_invert_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
      .wb_dat_o, .wb_ack_o, .fp_error_out_o, .internal_error_out_o, .bus_txn_o,
      .fp_exception_o, .maskable_irq_o, .nmi_o, .local_irq_o, .bus_lock_o, .snoop_hit_o,
      .snoop_hit_modified_o, .overtemp_flag_o, .overtemp_flag_oe_o, .throttle_active_o,
      .core_clk_en_o, .bus_clk_en_o, .sys_mgmt_mode_o, .builtin_self_test_o,
      .cache_invalidate_o, .int_reg_reset_o, .outputs_tristate_o, .pwr_state_o);
   psc_chipset_model #(.POR_CYC(20000)) i_chip (.clk_i, .bus_txn_i(bus_txn_o),
      .bus_lock_i(bus_lock_o), .hard_reset_o(hard_reset_i), .stop_clock_req_o(stop_clock_req_i),
      .sleep_req_o(sleep_req_i), .deep_sleep_req_o(deep_sleep_req_i),
      .soft_init_o(soft_init_i), .sys_mgmt_irq_o(sys_mgmt_irq_i),
      .data_strobe_pos_o(data_strobe_pos_i), .data_o(data_i), .data_invert_o(data_invert_i));
   // 10 MHz clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // one classic cycle; request held until ack is sampled high at a rising edge
   task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog well beyond power-on reset plus the test sequence
   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      i_chip.hard_reset(20000, 1'b0, 1'b0);
      step(4);
      `CHK("pwr", 4'h1, pwr_state_o)
      `CHK("clk", 2'b11, {core_clk_en_o, bus_clk_en_o})
      wb(1'b0, 32'(PSC_CTRL_OFS), 32'h0);
      `CHK("ctrl", 32'h2, rdat)
      wb(1'b1, 32'h10, 32'hff);
      wb(1'b0, 32'h10, 32'h0);
      `CHK("unmapped", 32'h0, rdat)
      // local irq pins, controller on then off
      local_irq_pins_i <= 2'b11;
      step(4);
      `CHK("lint", 4'b1100, {local_irq_o, maskable_irq_o, nmi_o})
      wb(1'b1, 32'(PSC_CTRL_OFS), 32'h0);
      local_irq_pins_i <= 2'b01;
      step(4);
      `CHK("maskable_irq", 2'b10, {maskable_irq_o, nmi_o})
      // numeric error and its masking
      wb(1'b1, 32'(PSC_EVT_OFS), 32'h1);
      ignore_numeric_error_i <= 1'b1;
      step(4);
      `CHK("fp_error_out", 1'b1, fp_error_out_o)
      `CHK("ignored", 1'b0, fp_exception_o)
      @(posedge clk_i) ignore_numeric_error_i <= 1'b0;
      step(4);
      `CHK("exc", 1'b1, fp_exception_o)
      @(posedge clk_i) ignore_numeric_error_i <= 1'b1;
      wb(1'b1, 32'(PSC_CTRL_OFS), 32'h1);
      step(4);
      `CHK("ne", 1'b1, fp_exception_o)
      wb(1'b1, 32'(PSC_EVT_OFS), 32'h10);
      step(1);
      `CHK("fclr", 1'b0, fp_error_out_o)
      // strobed groups land only in their own slice
      i_chip.strobe(4'b0001, 64'h0123_4567_89ab_cdef, 4'h1);
      i_chip.strobe(4'b0010, 64'hfedc_ba98_7654_3210, 4'hd);
      i_chip.strobe(4'b1100, 64'h5555_5555_5555_5555, 4'hc);
      wb(1'b0, 32'(PSC_DATA_LO_OFS), 32'h0);
      `CHK("data", 32'h7654_cdef, rdat)
      wb(1'b0, 32'(PSC_STAT_OFS), 32'h0);
      `CHK("inv", 8'hd1, rdat[15:8])
      // snoop stall drives both lines together
      wb(1'b1, 32'(PSC_CTRL_OFS), 32'h12);
      snoop_req_i <= 1'b1;
      `WAITHI(snoop_hit_o)
      `CHK("stall", 2'b11, {snoop_hit_o, snoop_hit_modified_o})
      @(posedge clk_i) snoop_req_i <= 1'b0;
      // power state walk with a break event pending
      i_chip.power(1'b1, 1'b0, 1'b0);
      step(4);
      `CHK("stopgnt", 6'b0010_01, {pwr_state_o, core_clk_en_o, bus_clk_en_o})
      `CHK("stopack", 1, i_chip.stopack_seen)
      wb(1'b1, 32'(PSC_EVT_OFS), 32'h2);
      step(6);
      `CHK("pbe", 1'b1, fp_error_out_o)
      i_chip.power(1'b1, 1'b1, 1'b0);
      step(5);
      `CHK("sleep", 6'b0100_00, {pwr_state_o, core_clk_en_o, bus_clk_en_o})
      @(posedge clk_i) snoop_req_i <= 1'b1;
      step(5);
      `CHK("nosnoop", 1'b0, snoop_hit_o)
      @(posedge clk_i) snoop_req_i <= 1'b0;
      i_chip.power(1'b1, 1'b1, 1'b1);
      step(4);
      `CHK("dsleep", 4'h8, pwr_state_o)
      i_chip.power(1'b1, 1'b1, 1'b0);
      step(4);
      `CHK("resleep", 4'h4, pwr_state_o)
      i_chip.power(1'b1, 1'b0, 1'b0);
      step(4);
      `CHK("wake", 6'b0010_01, {pwr_state_o, core_clk_en_o, bus_clk_en_o})
      `CHK("pbehold", 1'b1, fp_error_out_o)
      i_chip.power(1'b0, 1'b0, 1'b0);
      step(4);
      `CHK("normal", 6'b0001_11, {pwr_state_o, core_clk_en_o, bus_clk_en_o})
      `CHK("pbeoff", 1'b0, fp_error_out_o)
      // locked sequence delays the priority agent
      wb(1'b1, 32'(PSC_CTRL_OFS), 32'ha);
      step(1);
      `CHK("lock", 1'b1, bus_lock_o)
      fork
         i_chip.prio_grab(waited);
         wb(1'b1, 32'(PSC_CTRL_OFS), 32'h6);
      join
      `CHK("waited", 1'b1, 1'(waited > 0))
      // bidirectional overtemp input, then internal throttle driving the pin
      overtemp_flag_i <= 1'b1;
      step(4);
      `CHK("tcc_in", 1'b1, throttle_active_o)
      @(posedge clk_i) overtemp_flag_i <= 1'b0;
      step(4);
      `CHK("tcc_off", 1'b0, throttle_active_o)
      wb(1'b1, 32'(PSC_EVT_OFS), 32'hc);
      step(2);
      `CHK("hot", 3'b111, {overtemp_flag_o, overtemp_flag_oe_o, throttle_active_o})
      `CHK("internal_error_out", 1'b1, internal_error_out_o)
      `CHK("halt", 1, i_chip.halt_seen)
      // management interrupt entry and exit
      i_chip.smi(1'b1);
      `WAITHI(sys_mgmt_mode_o)
      i_chip.smi(1'b0);
      step(2);
      `CHK("smiack", 1, i_chip.smiack_seen)
      wb(1'b1, 32'(PSC_EVT_OFS), 32'h20);
      step(1);
      `CHK("smmexit", 1'b0, sys_mgmt_mode_o)
      // soft init resets integer state only
      i_chip.soft_init(1'b1);
      `WAITHI(int_reg_reset_o)
      `CHK("init", 6'b1_0_0001, {int_reg_reset_o, cache_invalidate_o, pwr_state_o})
      i_chip.soft_init(1'b0);
      // hard reset released with init, then with the management irq
      for (int i = 0; i < 2; i++) begin
         fork
            i_chip.hard_reset(10, 1'(i == 0), 1'(i == 1));
            begin
               `WAITHI(cache_invalidate_o)
               `CHK("inval", 1'b1, cache_invalidate_o)
               step(2);
               `CHK("outs", 2'b00, {internal_error_out_o, overtemp_flag_o})
               `WAITHI(i == 0 ? builtin_self_test_o : outputs_tristate_o)
               `CHK("release", 1'b1, i ? outputs_tristate_o : builtin_self_test_o)
            end
         join
      end
      wrap_up();
   end
endmodule // psc_top_tb
